// File: mmp_pkg.sv
package mmp_pkg;
	// port geometry defaults and limits
	localparam int MMP_DATA_W_DEF  = 32;
	localparam int MMP_ADDR_W_DEF  = 32;
	localparam int MMP_SLV_AW_DEF  = 4;
	localparam int MMP_BURST_W_DEF = 4;
	localparam int MMP_DATA_W_MAX  = 1024;
	localparam int MMP_ADDR_W_MAX  = 32;
	localparam int MMP_BURST_W_MIN = 2;
	localparam int MMP_BURST_W_MAX = 32;
	// pipelined read latency of the slave, in cycles
	localparam int MMP_RD_LAT      = 2;
	// reset values
	localparam logic MMP_BIT_RST   = 1'b0;
	// irq raised when the slave store holds this many written words
	localparam int MMP_IRQ_FILL    = 4;

	// true when x is a power of two
	function automatic bit mmp_is_pow2(input int x);
		return (x > 0) && ((x & (x - 1)) == 0);
	endfunction

	typedef enum logic [3:0] {
		MMP_M_IDLE = 4'b0001,
		MMP_M_REQ  = 4'b0010,
		MMP_M_WAIT = 4'b0100,
		MMP_M_DONE = 4'b1000
	} mmp_mst_e;
endpackage

// File: mmp_mem.sv
`timescale 1ns/1ps
module mmp_mem
	import mmp_pkg::*;
#(
	parameter int DATA_W = MMP_DATA_W_DEF,
	parameter int AW     = MMP_SLV_AW_DEF
) (
	input  wire logic              clk_sys,
	input  wire logic              wr_en,
	input  wire logic [AW-1:0]     wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [AW-1:0]     rd_addr,
	output logic      [DATA_W-1:0] rd_data_q
);
	logic [DATA_W-1:0] mem [0:(1<<AW)-1];

	// storage has no reset; read data is registered
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data_q <= mem[rd_addr];
	end
endmodule

// File: mmp_port.sv
`timescale 1ns/1ps
// Function
// [R1] read-valid marks edge of valid read data
// [R2] burst count 2-32 bits, needs wait-request
// [R3] burst start only in first burst cycle
// [R4] separate write-ready and read-available outputs
// [R5] one shared data bus, 1 to 1024 bits
// [R6] no drive while output enable low; the port stops driving one edge after it falls
// [R7] interrupt asserted while service is needed
// [R8] reset gives a deterministic state
// [R9] dynamic sizing needs power-of-two widths
// [R10] read and write data equal width
// [R11] any slave signal may be unused
// [R12] master signals synchronous to one clock
// [R13] master holds transfer during wait-request
// [R14] master byte address, word aligned only
// [R15] master read needs a read data bus
// [R16] master read data power of two, 8-1024
// [R17] inputs ignored unless chip select asserted
// [R18] read-valid one cycle per word
module mmp_port
	import mmp_pkg::*;
#(
	parameter int DATA_W  = MMP_DATA_W_DEF,
	parameter int ADDR_W  = MMP_ADDR_W_DEF,
	parameter int SLV_AW  = MMP_SLV_AW_DEF,
	parameter int BURST_W = MMP_BURST_W_DEF,
	parameter bit DYN_SZ  = 1'b1
) (
	input  wire logic               clk_sys,
	input  wire logic               rst_b,
	// slave port
	input  wire logic               s_chipselect,
	input  wire logic [SLV_AW-1:0]  s_address,
	input  wire logic               s_read,
	input  wire logic               s_write,
	input  wire logic [BURST_W-1:0] s_burstcount,
	input  wire logic               s_beginbursttransfer,
	input  wire logic               s_outputenable,
	input  wire logic [DATA_W-1:0]  s_data_i,
	output logic      [DATA_W-1:0]  s_data_o,
	output logic                    s_data_oe,
	output logic                    s_waitrequest,
	output logic                    s_readdatavalid,
	output logic                    s_readyfordata,
	output logic                    s_dataavailable,
	output logic                    s_irq,
	// user side of the master port
	input  wire logic               u_rd_start,
	input  wire logic [ADDR_W-1:0]  u_rd_addr,
	output logic      [DATA_W-1:0]  u_rd_data,
	output logic                    u_rd_done,
	// master port
	input  wire logic               m_waitrequest,
	input  wire logic [DATA_W-1:0]  m_readdata,
	output logic      [ADDR_W-1:0]  m_address,
	output logic                    m_read
);
	localparam int BYTE_SH = $clog2(DATA_W / 8);
	localparam int CNT_W   = SLV_AW + 1;

	// geometry checks at elaboration, widths are fixed by parameters
	if (DATA_W < 1 || DATA_W > MMP_DATA_W_MAX) $error("bad data width"); // [R5]
	if (DYN_SZ && !mmp_is_pow2(DATA_W)) $error("data width not power of two"); // [R9]
	if (DATA_W < 8 || !mmp_is_pow2(DATA_W)) $error("master read width illegal"); // [R16]
	if (BURST_W < MMP_BURST_W_MIN || BURST_W > MMP_BURST_W_MAX) $error("bad burst width"); // [R2]
	if (ADDR_W < 1 || ADDR_W > MMP_ADDR_W_MAX) $error("bad address width"); // [R14]

	// slave side
	// one data width serves both directions on the shared bus [R10]
	logic [SLV_AW-1:0]  wadr_q, wadr_d;
	logic [SLV_AW-1:0]  radr_q, radr_d;
	logic [CNT_W-1:0]   fill_q, fill_d;
	logic [BURST_W-1:0] brem_q, brem_d;
	logic               bwr_q, bwr_d;
	logic [MMP_RD_LAT-1:0] vpipe_q, vpipe_d;
	logic               oe_q, oe_d;
	logic               irq_q, irq_d;
	logic               rfd_q, rfd_d;
	logic               dav_q, dav_d;
	logic               wait_q, wait_d;
	logic               mem_wr;
	logic               rd_take;
	logic [DATA_W-1:0]  mem_rd;
	logic               is_full, is_empty;

	mmp_mem #(.DATA_W(DATA_W), .AW(SLV_AW)) u_mem (
		.clk_sys   (clk_sys),
		.wr_en     (mem_wr),
		.wr_addr   (wadr_q),
		.wr_data   (s_data_i),
		.rd_addr   (radr_q),
		.rd_data_q (mem_rd)
	);

	// full test shared by the write gate, the stall and the ready flag, so they never disagree
	function automatic logic fill_full(input logic [CNT_W-1:0] f);
		return f == CNT_W'(1 << SLV_AW);
	endfunction

	// the slave is a word store read and written as a queue; address is accepted but unused [R11]
	always_comb begin
		is_full  = fill_full(fill_q);
		is_empty = (fill_q == '0);
		// writes and reads only count under chip select [R17]
		mem_wr  = s_chipselect && s_write && !is_full && !wait_q;
		rd_take = s_chipselect && s_read && !is_empty && !wait_q && !mem_wr;
		wadr_d  = mem_wr ? wadr_q + 1'b1 : wadr_q;
		radr_d  = rd_take ? radr_q + 1'b1 : radr_q;
		fill_d  = fill_q;
		if (mem_wr) begin
			fill_d = fill_q + 1'b1;
		end else if (rd_take) begin
			fill_d = fill_q - 1'b1;
		end
		// burst counter: loaded only on burst start, counts accepted beats [R3]
		brem_d = brem_q;
		bwr_d  = bwr_q;
		if (s_chipselect && s_beginbursttransfer) begin
			brem_d = s_burstcount;
			bwr_d  = s_write;
		end else if ((mem_wr || rd_take) && brem_q != '0) begin
			brem_d = brem_q - 1'b1;
		end
		// stall when a beat cannot be taken; needed with burst count [R2]
		wait_d = (s_chipselect && s_write && fill_full(fill_d))
			|| (s_chipselect && s_read && fill_d == '0);
		// one valid pulse per taken read, fixed latency [R1] [R18]
		vpipe_d = {vpipe_q[MMP_RD_LAT-2:0], rd_take};
		// drive enable is output enable under chip select, registered one edge late [R6]
		oe_d  = s_chipselect && s_outputenable;
		rfd_d = !fill_full(fill_d); // [R4]
		dav_d = (fill_d != '0); // [R4]
		irq_d = (fill_d >= CNT_W'(MMP_IRQ_FILL)); // [R7]
	end

	// registers reset synchronously to a fixed state [R8]
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			wadr_q  <= '0;
			radr_q  <= '0;
			fill_q  <= '0;
			brem_q  <= '0;
			bwr_q   <= MMP_BIT_RST;
			vpipe_q <= '0;
			oe_q    <= MMP_BIT_RST;
			irq_q   <= MMP_BIT_RST;
			rfd_q   <= MMP_BIT_RST;
			dav_q   <= MMP_BIT_RST;
			wait_q  <= MMP_BIT_RST;
		end else begin
			wadr_q  <= wadr_d;
			radr_q  <= radr_d;
			fill_q  <= fill_d;
			brem_q  <= brem_d;
			bwr_q   <= bwr_d;
			vpipe_q <= vpipe_d;
			oe_q    <= oe_d;
			irq_q   <= irq_d;
			rfd_q   <= rfd_d;
			dav_q   <= dav_d;
			wait_q  <= wait_d;
		end
	end

	// read data leaves a register and holds until the next valid word [R18]
	logic [DATA_W-1:0] rdat_q, rdat_d;
	always_comb begin
		rdat_d = vpipe_q[0] ? mem_rd : rdat_q;
	end
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			rdat_q <= '0;
		end else begin
			rdat_q <= rdat_d;
		end
	end

	assign s_data_o        = rdat_q; // [R5]
	assign s_data_oe       = oe_q; // [R6]
	assign s_readdatavalid = vpipe_q[MMP_RD_LAT-1]; // [R1]
	assign s_waitrequest   = wait_q; // [R2]
	assign s_readyfordata  = rfd_q;
	assign s_dataavailable = dav_q;
	assign s_irq           = irq_q;

	// master side
	mmp_mst_e          mst_q, mst_d;
	logic [ADDR_W-1:0] madr_q, madr_d;
	logic              mrd_q, mrd_d;
	logic [DATA_W-1:0] mdat_q, mdat_d;
	logic              mdone_q, mdone_d;

	// one read at a time; address is forced to a word boundary [R14]
	always_comb begin
		mst_d   = mst_q;
		madr_d  = madr_q;
		mrd_d   = mrd_q;
		mdat_d  = mdat_q;
		mdone_d = 1'b0;
		case (mst_q)
			MMP_M_IDLE: begin
				if (u_rd_start) begin
					madr_d = (u_rd_addr >> BYTE_SH) << BYTE_SH; // [R14]
					mrd_d  = 1'b1;
					mst_d  = MMP_M_REQ;
				end
			end
			MMP_M_REQ, MMP_M_WAIT: begin
				// address and read stay put while the fabric stalls [R13]
				if (!m_waitrequest) begin
					mdat_d = m_readdata; // [R15]
					mrd_d  = 1'b0;
					mdone_d = 1'b1;
					mst_d  = MMP_M_DONE;
				end else begin
					mst_d = MMP_M_WAIT;
				end
			end
			MMP_M_DONE: begin
				mst_d = MMP_M_IDLE;
			end
			default: begin
				mst_d = MMP_M_IDLE;
				mrd_d = 1'b0;
			end
		endcase
	end

	// all master signals run on clk_sys [R12]
	always_ff @(posedge clk_sys) begin
		if (!rst_b) begin
			mst_q   <= MMP_M_IDLE;
			madr_q  <= '0;
			mrd_q   <= MMP_BIT_RST;
			mdat_q  <= '0;
			mdone_q <= MMP_BIT_RST;
		end else begin
			mst_q   <= mst_d;
			madr_q  <= madr_d;
			mrd_q   <= mrd_d;
			mdat_q  <= mdat_d;
			mdone_q <= mdone_d;
		end
	end

	assign m_address = madr_q;
	assign m_read    = mrd_q;
	assign u_rd_data = mdat_q;
	assign u_rd_done = mdone_q;
endmodule

// File: mmp_port_props.sv
`timescale 1ns/1ps
module mmp_port_chk
	import mmp_pkg::*;
#(
	parameter int DATA_W = MMP_DATA_W_DEF,
	parameter int ADDR_W = MMP_ADDR_W_DEF,
	parameter int SLV_AW = MMP_SLV_AW_DEF
) (
	input wire logic              clk_sys,
	input wire logic              rst_b,
	input wire logic              s_chipselect,
	input wire logic              s_read,
	input wire logic              s_write,
	input wire logic              s_outputenable,
	input wire logic              s_data_oe,
	input wire logic              s_waitrequest,
	input wire logic              s_readdatavalid,
	input wire logic              s_readyfordata,
	input wire logic              s_dataavailable,
	input wire logic              s_irq,
	input wire logic [DATA_W-1:0] u_rd_data,
	input wire logic              u_rd_done,
	input wire logic              m_waitrequest,
	input wire logic [DATA_W-1:0] m_readdata,
	input wire logic [ADDR_W-1:0] m_address,
	input wire logic              m_read
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// a read is taken when data is there and no write wins the same beat
	AST_RD_LAT: assert property (s_chipselect && s_read && !s_waitrequest && s_dataavailable
		&& !(s_write && s_readyfordata) |-> ##2 s_readdatavalid)
		else $error("read valid late");
	AST_RD_SRC: assert property (s_readdatavalid |-> $past(s_chipselect && s_read && !s_waitrequest
		&& s_dataavailable && !(s_write && s_readyfordata), 2))
		else $error("read valid without read");
	AST_OE_OFF: assert property (!s_outputenable |=> !s_data_oe)
		else $error("data driven without enable");
	AST_CS_IDLE: assert property (!s_chipselect [*3] |=> $stable(s_dataavailable) && $stable(s_readyfordata))
		else $error("state moved while deselected");
	// irq means full only when the store holds no more than the threshold
	AST_IRQ_FULL: assert property (s_irq |-> s_dataavailable
		&& (!s_readyfordata || (1 << SLV_AW) > MMP_IRQ_FILL))
		else $error("irq without fill");
	AST_M_HOLD: assert property (m_read && m_waitrequest |=> m_read && $stable(m_address))
		else $error("master dropped stalled read");
	AST_M_ALIGN: assert property (m_read |-> (m_address % (DATA_W / 8)) == 0)
		else $error("master address unaligned");
	AST_M_DONE: assert property (m_read && !m_waitrequest |=> u_rd_done && !m_read
		&& u_rd_data == $past(m_readdata))
		else $error("master read not completed");
endmodule

bind mmp_port mmp_port_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .SLV_AW(SLV_AW)) u_chk (.*);

// File: mmp_fabric.sv
`timescale 1ns/1ps
module mmp_fabric (
	input  wire logic [3:0]  stall,
	input  wire logic        clk_sys,
	input  wire logic        m_read,
	input  wire logic [7:0]  m_address,
	output logic             m_waitrequest,
	output logic      [31:0] m_readdata
);
	int   cnt = 0;
	logic tog = 1'b0;
	// stall count of the current read, everything moves on the port clock
	always @(posedge clk_sys) begin
		cnt <= (m_read && m_waitrequest) ? cnt + 1 : 0;
		tog <= ~tog;
	end
	// outside the answer cycle the data toggles so stale words never match
	assign m_waitrequest = m_read && (cnt < stall);
	assign m_readdata = (m_read && !m_waitrequest) ? {4{m_address}} ^ 32'h5a5a5a5a : {32{tog}};
endmodule

// File: test_mm_port_signalling_subset.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_mm_port_signalling_subset;
	import mmp_pkg::*;
	logic        clk_sys = 0, rst_b = 0, s_chipselect = 0, s_read = 0, s_write = 0;
	logic        s_beginbursttransfer = 0, s_outputenable = 0, u_rd_start = 0;
	logic [1:0]  s_address = 0;
	logic [3:0]  s_burstcount = 4, stall = 0;
	logic [7:0]  u_rd_addr = 0, m_address;
	logic [31:0] s_data_i = 0, s_data_o, m_readdata, u_rd_data, seed = 64116, tmp, e;
	logic        s_data_oe, s_waitrequest, s_readdatavalid, s_readyfordata, s_dataavailable;
	logic        s_irq, u_rd_done, m_waitrequest, m_read;
	int          errors = 0, n_tests = 0, fill = 0;
	logic [31:0] mem[$], eq[$], mq[$];
	mmp_port #(.ADDR_W(8), .SLV_AW(2)) uut (.*);
	mmp_fabric fab (.*);
	always #10 clk_sys = ~clk_sys;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task final_report;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// one slave request for one edge, then an idle edge so the flags settle
	task op(input logic w, input logic r, input logic c);
		@(negedge clk_sys);
		`CHK({s_readyfordata, s_dataavailable, s_irq}, {fill < 4, fill > 0, fill >= MMP_IRQ_FILL})
		tmp = xs();
		{s_chipselect, s_write, s_read, s_data_i, s_address} = {c, w, r, tmp, tmp[1:0]};
		s_beginbursttransfer = c && w && fill == 0;
		@(posedge clk_sys);
		if (c && w && fill < 4) begin mem.push_back(tmp); fill++; end
		else if (c && r && fill > 0) begin eq.push_back(mem.pop_front()); fill--; end
		@(negedge clk_sys);
		// stall shows one edge after a beat that leaves the store full or empty
		`CHK(s_waitrequest, c && (w && fill == 4 || r && fill == 0))
		{s_chipselect, s_write, s_read, s_beginbursttransfer} = 4'h0;
	endtask
	task mr(input int st);
		@(negedge clk_sys);
		tmp = xs();
		{stall, u_rd_start, u_rd_addr} = {st[3:0], 1'b1, tmp[7:0]};
		mq.push_back({4{tmp[7:0] & 8'hfc}} ^ 32'h5a5a5a5a);
		@(negedge clk_sys);
		u_rd_start = 0;
		repeat (st + 6) @(negedge clk_sys);
	endtask
	task rst_chk;
		`CHK({s_data_oe, s_waitrequest, s_readdatavalid, s_readyfordata, s_dataavailable, s_irq, u_rd_done, m_read}, 8'h0)
		mem.delete();
		fill = 0;
		rst_b = 1;
	endtask
	// results are matched against the oldest note whenever they appear
	always @(posedge clk_sys) begin
		#1;
		if (s_readdatavalid === 1'b1) begin
			e = eq.size() ? eq.pop_front() : 'x;
			`CHK(s_data_o, e)
		end
		if (u_rd_done === 1'b1) begin
			e = mq.size() ? mq.pop_front() : 'x;
			`CHK(u_rd_data, e)
		end
	end
	// main sequence: fill past full, read and write together, deselected requests, drain past empty, reset mid-run
	initial begin
		repeat (5) @(negedge clk_sys);
		rst_chk();
		repeat (5) op(1, 0, 1);
		// store full: the read of a joint request goes through
		op(1, 1, 1);
		op(1, 0, 0);
		op(0, 1, 0);
		repeat (5) op(0, 1, 1);
		repeat (2) op(1, 0, 1);
		@(negedge clk_sys) rst_b = 0;
		@(negedge clk_sys) rst_chk();
		repeat (2) op(1, 0, 1);
		// room left: the write of a joint request wins
		op(1, 1, 1);
		repeat (2) op(0, 1, 1);
		@(negedge clk_sys) {s_chipselect, s_outputenable} = 2'h3;
		@(negedge clk_sys) `CHK(s_data_oe, 1'b1)
		s_outputenable = 0;
		@(negedge clk_sys) `CHK(s_data_oe, 1'b0)
		s_chipselect = 0;
		for (int i = 0; i < 4; i++) mr(i);
		repeat (5) @(negedge clk_sys);
		`CHK(eq.size() + mq.size(), 0)
		final_report();
	end
	// hang guard, far beyond the under one hundred cycles the sequence needs
	initial begin
		#100000;
		errors++;
		final_report();
	end
endmodule
